// ===== logic/wor_option_regs.sv
/*
 * Write-once option register bank: two configuration registers that
 * take one write per reset, and a read-only view of the flash option
 * byte. Assumes an APB master on MCLK_IN, the flash array presenting
 * the option byte on OPTION_BYTE_IN, and the watchdog, voltage
 * monitor, oscillators and CPU decoding the control outputs.
 */
`timescale 1ns/1ns
`default_nettype none

module wor_option_regs (
  // Clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RST_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Flash option byte
  input  wire logic [7:0]  OPTION_BYTE_IN,
  // System events
  input  wire logic        STOP_MODE_IN,
  input  wire logic        STOP_EXIT_PIN_IN,
  input  wire logic        STOP_OPCODE_IN,
  input  wire logic        MON_RESET_REQ_IN,
  // Watchdog control
  output logic             WDOG_ENABLE_OUT,
  output logic      [17:0] WDOG_TIMEOUT_OUT,
  // Low-voltage monitor control
  output logic             SUPPLY_MON_EN_OUT,
  output logic             REGULATOR_MON_EN_OUT,
  output logic             MON_ACTIVE_OUT,
  output logic             MON_RESET_OUT,
  // Stop mode control
  output logic      [12:0] STOP_RECOVERY_OUT,
  output logic             STOP_ENTER_OUT,
  output logic             ILLEGAL_OPCODE_OUT,
  // Oscillator and clock routing
  output logic             INTOSC_RUN_OUT,
  output logic             RCOSC_RUN_OUT,
  output logic             XTAL_RUN_OUT,
  output logic      [1:0]  TIMEBASE_CLK_SEL_OUT,
  output logic             SERIAL_BAUD_BUS_OUT,
  output logic      [1:0]  MAIN_OSC_SEL_OUT,
  // Lock status
  output logic             CFG_ONE_LOCKED_OUT,
  output logic             CFG_TWO_LOCKED_OUT
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic wor_pkg::wor_sel_t decode(input logic [11:0] addr);
    wor_pkg::wor_sel_t sel;
    sel = wor_pkg::SEL_NONE;
    if (addr == wor_pkg::CFG_ONE_ADDR) begin
      sel = wor_pkg::SEL_ONE;
    end else if (addr == wor_pkg::CFG_TWO_ADDR) begin
      sel = wor_pkg::SEL_TWO;
    end else if (addr == wor_pkg::OPT_ADDR) begin
      sel = wor_pkg::SEL_OPT;
    end
    return sel;
  endfunction

  wor_pkg::wor_sel_t     sel;
  logic                  setup;
  logic                  wr_commit;
  logic [1:0]            hit;
  logic [7:0]            cfg_q [2];
  logic [7:0]            cfg_d [2];
  logic                  lock_q [2];
  logic                  lock_d [2];
  wor_pkg::wor_cfg_one_t cfg_one;
  wor_pkg::wor_cfg_two_t cfg_two;
  wor_pkg::wor_ctl_t     ctl_q;
  wor_pkg::wor_ctl_t     ctl_d;
  logic [31:0]           prdata_q;
  logic [31:0]           prdata_d;
  logic                  ready_q;
  logic                  ready_d;
  logic                  err_q;
  logic                  err_d;

  assign sel       = decode(PADDR_IN);
  assign setup     = PSEL_IN && !PENABLE_IN;
  // A write lands only at the access edge with PREADY high
  assign wr_commit = PSEL_IN && PENABLE_IN && PWRITE_IN && ready_q &&
                     PSTRB_IN[0];
  assign hit       = {sel == wor_pkg::SEL_TWO, sel == wor_pkg::SEL_ONE};
  assign cfg_one   = wor_pkg::wor_cfg_one_t'(cfg_q[0]);
  assign cfg_two   = wor_pkg::wor_cfg_two_t'(cfg_q[1]);

  // ****************************************************************
  // Write-once configuration latches (0 = config_one, 1 = config_two)
  // ****************************************************************
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_cfg
    localparam logic [7:0] WMASK = (gi == 0) ? wor_pkg::CFG_ONE_WMASK :
                                               wor_pkg::CFG_TWO_WMASK;
    always_comb begin
      cfg_d[gi]  = cfg_q[gi];
      lock_d[gi] = lock_q[gi];
      // Once locked, further writes fall through unseen
      if (wr_commit && hit[gi] && !lock_q[gi]) begin
        cfg_d[gi]  = PWDATA_IN[7:0] & WMASK;
        lock_d[gi] = 1'b1;
      end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        cfg_q[gi]  <= wor_pkg::CFG_RESET;
        lock_q[gi] <= 1'b0;
      end else begin
        cfg_q[gi]  <= cfg_d[gi];
        lock_q[gi] <= lock_d[gi];
      end
    end
  end

  // ****************************************************************
  // APB answer: zero wait states, data and status from flops
  // ****************************************************************
  always_comb begin
    ready_d  = 1'b0;
    err_d    = 1'b0;
    prdata_d = prdata_q;
    if (setup) begin
      ready_d  = 1'b1;
      // Writes to the flash byte are refused; it changes by programming
      err_d    = (sel == wor_pkg::SEL_NONE) ||
                 (PWRITE_IN && sel == wor_pkg::SEL_OPT);
      prdata_d = 32'h0000_0000;
      if (!PWRITE_IN) begin
        case (sel)
          wor_pkg::SEL_ONE: prdata_d = {24'h00_0000, cfg_q[0]};
          wor_pkg::SEL_TWO: prdata_d = {24'h00_0000, cfg_q[1]};
          wor_pkg::SEL_OPT: prdata_d = {24'h00_0000, ctl_q.opt_byte};
          default:          prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      prdata_q <= 32'h0000_0000;
      ready_q  <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      ready_q  <= ready_d;
      err_q    <= err_d;
    end
  end

  // ****************************************************************
  // Control outputs decoded from the option settings
  // ****************************************************************
  always_comb begin
    ctl_d = ctl_q;
    ctl_d.wdog_en      = !cfg_one.watchdog_dis;
    ctl_d.wdog_timeout = cfg_one.watchdog_rate_sel ?
                         wor_pkg::WD_FAST_CNT :
                         wor_pkg::WD_SLOW_CNT;
    // A monitor circuit runs unless disabled, and in stop only if kept
    ctl_d.supply_mon_en = !cfg_one.supply_monitor_dis &&
                          (!STOP_MODE_IN || cfg_one.monitor_stop_en);
    ctl_d.reg_mon_en    = !cfg_one.regulator_monitor_dis &&
                          (!STOP_MODE_IN || cfg_one.monitor_stop_en);
    ctl_d.mon_active    = (!cfg_one.supply_monitor_dis ||
                           !cfg_one.regulator_monitor_dis) &&
                          (!STOP_MODE_IN || cfg_one.monitor_stop_en);
    ctl_d.mon_reset     = MON_RESET_REQ_IN &&
                          !cfg_one.monitor_reset_dis;
    // Reset-pin exit ignores the short option: the long wait covers the
    // monitor's turn-on time
    if (STOP_EXIT_PIN_IN || !cfg_one.short_recovery) begin
      ctl_d.stop_recovery = wor_pkg::REC_LONG;
    end else begin
      ctl_d.stop_recovery = wor_pkg::REC_SHORT;
    end
    ctl_d.stop_enter     = STOP_OPCODE_IN && cfg_one.stop_instr_en;
    ctl_d.illegal_opcode = STOP_OPCODE_IN &&
                           !cfg_one.stop_instr_en;
    // Internal oscillator stops only in stop mode when asked to
    ctl_d.intosc_run = !(STOP_MODE_IN &&
                         cfg_two.intosc_stop_dis);
    ctl_d.rcosc_run  = !STOP_MODE_IN || cfg_two.rcosc_stop_en;
    ctl_d.xtal_run   = !STOP_MODE_IN || cfg_two.xtal_stop_en;
    // Code 11 is unused and passed on as written
    ctl_d.timebase_sel = cfg_two.timebase_clk_sel;
    ctl_d.baud_bus     = cfg_two.serial_baud_src;
    // Option byte follows the flash array; reset loads the erased value OPT_ERASED
    ctl_d.opt_byte     = OPTION_BYTE_IN;
    ctl_d.main_osc_sel = OPTION_BYTE_IN[wor_pkg::OPT_SEL_MSB:
                                        wor_pkg::OPT_SEL_LSB];
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctl_q <= wor_pkg::CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ****************************************************************
  // Port assignments
  // ****************************************************************
  assign PRDATA_OUT           = prdata_q;
  assign PREADY_OUT           = ready_q;
  assign PSLVERR_OUT          = err_q;
  assign WDOG_ENABLE_OUT      = ctl_q.wdog_en;
  assign WDOG_TIMEOUT_OUT     = ctl_q.wdog_timeout;
  assign SUPPLY_MON_EN_OUT    = ctl_q.supply_mon_en;
  assign REGULATOR_MON_EN_OUT = ctl_q.reg_mon_en;
  assign MON_ACTIVE_OUT       = ctl_q.mon_active;
  assign MON_RESET_OUT        = ctl_q.mon_reset;
  assign STOP_RECOVERY_OUT    = ctl_q.stop_recovery;
  assign STOP_ENTER_OUT       = ctl_q.stop_enter;
  assign ILLEGAL_OPCODE_OUT   = ctl_q.illegal_opcode;
  assign INTOSC_RUN_OUT       = ctl_q.intosc_run;
  assign RCOSC_RUN_OUT        = ctl_q.rcosc_run;
  assign XTAL_RUN_OUT         = ctl_q.xtal_run;
  assign TIMEBASE_CLK_SEL_OUT = ctl_q.timebase_sel;
  assign SERIAL_BAUD_BUS_OUT  = ctl_q.baud_bus;
  assign MAIN_OSC_SEL_OUT     = ctl_q.main_osc_sel;
  assign CFG_ONE_LOCKED_OUT   = lock_q[0];
  assign CFG_TWO_LOCKED_OUT   = lock_q[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  lock_one_a: assert property (lock_q[0] |=> $stable(cfg_q[0]))
    else $error("config_one changed after its first write");

  lock_two_a: assert property (lock_q[1] |=> $stable(cfg_q[1]))
    else $error("config_two changed after its first write");

  first_write_a: assert property (
    (wr_commit && hit[0] && !lock_q[0]) |=>
      lock_q[0] && cfg_q[0] == $past(PWDATA_IN[7:0]))
    else $error("first write to config_one not latched");

  reset_clear_a: assert property (
    $past(RST_IN) |-> cfg_q[0] == wor_pkg::CFG_RESET &&
      cfg_q[1] == wor_pkg::CFG_RESET && !lock_q[0] && !lock_q[1])
    else $error("configuration not clear after reset");

  read_back_a: assert property (
    (setup && !PWRITE_IN && sel == wor_pkg::SEL_TWO) |=>
      PREADY_OUT && PRDATA_OUT == {24'h00_0000, $past(cfg_q[1])})
    else $error("config_two read returned wrong data");

  late_write_a: assert property (
    (wr_commit && hit[0] && lock_q[0]) |-> !PSLVERR_OUT ##1
      cfg_q[0] == $past(cfg_q[0]))
    else $error("late write to config_one had an effect");

  late_two_a: assert property (
    (wr_commit && hit[1] && lock_q[1]) |-> !PSLVERR_OUT ##1
      cfg_q[1] == $past(cfg_q[1]))
    else $error("late write to config_two had an effect");

  two_write_a: assert property (
    (wr_commit && hit[1] && !lock_q[1]) |=> lock_q[1] &&
      cfg_q[1] == ($past(PWDATA_IN[7:0]) & wor_pkg::CFG_TWO_WMASK))
    else $error("first write to config_two not latched");

  wd_rate_a: assert property (
    $stable(cfg_q[0]) [*2] |-> WDOG_TIMEOUT_OUT ==
      (cfg_one.watchdog_rate_sel ? 18'h0_1FF0 : 18'h3_FFF0))
    else $error("watchdog timeout does not match rate bit");

  mon_stop_a: assert property (
    (STOP_MODE_IN && !cfg_one.monitor_stop_en) |=>
      !MON_ACTIVE_OUT && !SUPPLY_MON_EN_OUT && !REGULATOR_MON_EN_OUT)
    else $error("monitor kept running in stop mode");

  mon_reset_a: assert property (
    MON_RESET_REQ_IN |=> MON_RESET_OUT == !$past(cfg_one.monitor_reset_dis))
    else $error("monitor reset not gated by disable bit");

  recovery_a: assert property (
    STOP_EXIT_PIN_IN || !cfg_one.short_recovery |=>
      STOP_RECOVERY_OUT == 13'h1000)
    else $error("long stop recovery not selected");

  stop_opcode_a: assert property (
    STOP_OPCODE_IN |=> (STOP_ENTER_OUT != ILLEGAL_OPCODE_OUT) &&
      STOP_ENTER_OUT == $past(cfg_one.stop_instr_en))
    else $error("stop opcode legality wrong");

  wdog_dis_a: assert property (
    cfg_one.watchdog_dis |=> !WDOG_ENABLE_OUT)
    else $error("watchdog left enabled");

  intosc_a: assert property (
    !STOP_MODE_IN |=> INTOSC_RUN_OUT)
    else $error("internal oscillator stopped outside stop mode");

  osc_stop_a: assert property (
    (STOP_MODE_IN && !cfg_two.rcosc_stop_en && cfg_two.xtal_stop_en) |=>
      !RCOSC_RUN_OUT && XTAL_RUN_OUT)
    else $error("oscillator stop control wrong");

  routing_a: assert property (
    $stable(cfg_q[1]) && $stable(OPTION_BYTE_IN) |=>
      TIMEBASE_CLK_SEL_OUT == $past(cfg_q[1][4:3]) &&
      SERIAL_BAUD_BUS_OUT == $past(cfg_q[1][0]) &&
      MAIN_OSC_SEL_OUT == $past(OPTION_BYTE_IN[7:6]))
    else $error("clock routing does not follow settings");

  short_rec_a: assert property (
    (!STOP_EXIT_PIN_IN && cfg_one.short_recovery) |=>
      STOP_RECOVERY_OUT == wor_pkg::REC_SHORT)
    else $error("short stop recovery not selected");

  reset_out_a: assert property (
    $past(RST_IN) |-> WDOG_ENABLE_OUT &&
      WDOG_TIMEOUT_OUT == wor_pkg::WD_SLOW_CNT &&
      TIMEBASE_CLK_SEL_OUT == wor_pkg::TB_INTOSC && !SERIAL_BAUD_BUS_OUT)
    else $error("outputs not at cleared settings after reset");

  opt_read_a: assert property (
    (setup && !PWRITE_IN && sel == wor_pkg::SEL_OPT &&
      $stable(OPTION_BYTE_IN)) |=>
      PRDATA_OUT == {24'h00_0000, $past(OPTION_BYTE_IN)})
    else $error("option byte read does not follow flash");

  rc_keep_a: assert property (
    (STOP_MODE_IN && cfg_two.rcosc_stop_en) |=> RCOSC_RUN_OUT)
    else $error("RC oscillator stopped although kept");

  intosc_off_a: assert property (
    (STOP_MODE_IN && cfg_two.intosc_stop_dis) |=> !INTOSC_RUN_OUT)
    else $error("internal oscillator kept running in stop");

endmodule

`default_nettype wire

// ===== pkg/wor_pkg.sv
/*
 * Constants, field layouts and carrier types for the write-once option
 * register bank. Assumes a 32-bit APB slave with 12-bit byte addresses.
 */
`default_nettype none

package wor_pkg;

  // ****************************************************************
  // Register map (index times four is the byte address)
  // ****************************************************************
  localparam int unsigned ADDR_W       = 12;
  localparam logic [9:0]  CFG_TWO_IDX  = 10'h01D;
  localparam logic [9:0]  CFG_ONE_IDX  = 10'h01F;
  localparam logic [9:0]  OPT_IDX      = 10'h020;
  localparam logic [11:0] CFG_TWO_ADDR = {CFG_TWO_IDX, 2'b00};
  localparam logic [11:0] CFG_ONE_ADDR = {CFG_ONE_IDX, 2'b00};
  localparam logic [11:0] OPT_ADDR     = {OPT_IDX, 2'b00};

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  OPT_ERASED    = 8'hFF;
  localparam logic [7:0]  CFG_ONE_WMASK = 8'hFF;
  localparam logic [7:0]  CFG_TWO_WMASK = 8'hF9;
  localparam int unsigned OPT_SEL_MSB   = 7;
  localparam int unsigned OPT_SEL_LSB   = 6;

  // ****************************************************************
  // Timing counts, in internal-oscillator cycles
  // ****************************************************************
  localparam int unsigned WD_FAST_EXP = 13;
  localparam int unsigned WD_SLOW_EXP = 18;
  localparam int unsigned WD_TRIM_EXP = 4;
  localparam int unsigned WD_CNT_W    = 18;
  localparam logic [17:0] WD_FAST_CNT =
    18'((1 << WD_FAST_EXP) - (1 << WD_TRIM_EXP));
  localparam logic [17:0] WD_SLOW_CNT =
    18'((1 << WD_SLOW_EXP) - (1 << WD_TRIM_EXP));
  localparam logic [12:0] REC_SHORT   = 13'h0020;
  localparam logic [12:0] REC_LONG    = 13'h1000;

  // ****************************************************************
  // Clock source codes
  // ****************************************************************
  localparam logic [1:0] TB_INTOSC   = 2'b00;
  localparam logic [1:0] TB_RCOSC    = 2'b01;
  localparam logic [1:0] TB_XTAL     = 2'b10;
  localparam logic [1:0] MAIN_ERASED = 2'b11;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {SEL_NONE, SEL_ONE, SEL_TWO, SEL_OPT} wor_sel_t;

  typedef struct packed {
    logic watchdog_rate_sel;
    logic monitor_stop_en;
    logic monitor_reset_dis;
    logic supply_monitor_dis;
    logic regulator_monitor_dis;
    logic short_recovery;
    logic stop_instr_en;
    logic watchdog_dis;
  } wor_cfg_one_t;

  typedef struct packed {
    logic       intosc_stop_dis;
    logic       rcosc_stop_en;
    logic       xtal_stop_en;
    logic [1:0] timebase_clk_sel;
    logic [1:0] spare;
    logic       serial_baud_src;
  } wor_cfg_two_t;

  typedef struct packed {
    logic        wdog_en;
    logic [17:0] wdog_timeout;
    logic        supply_mon_en;
    logic        reg_mon_en;
    logic        mon_active;
    logic        mon_reset;
    logic [12:0] stop_recovery;
    logic        stop_enter;
    logic        illegal_opcode;
    logic        intosc_run;
    logic        rcosc_run;
    logic        xtal_run;
    logic [1:0]  timebase_sel;
    logic        baud_bus;
    logic [1:0]  main_osc_sel;
    logic [7:0]  opt_byte;
  } wor_ctl_t;

  localparam wor_ctl_t CTL_RESET = '{
    wdog_en:        1'b1,
    wdog_timeout:   WD_SLOW_CNT,
    supply_mon_en:  1'b1,
    reg_mon_en:     1'b1,
    mon_active:     1'b1,
    mon_reset:      1'b0,
    stop_recovery:  REC_LONG,
    stop_enter:     1'b0,
    illegal_opcode: 1'b0,
    intosc_run:     1'b1,
    rcosc_run:      1'b1,
    xtal_run:       1'b1,
    timebase_sel:   TB_INTOSC,
    baud_bus:       1'b0,
    main_osc_sel:   MAIN_ERASED,
    opt_byte:       OPT_ERASED
  };

endpackage

`default_nettype wire

// ===== dv/tb.sv
/*
 * Self-checking bench for the write-once option register bank.
 * Assumes the APB slave answers with PREADY in the access phase and
 * that control outputs follow their causes one clock later.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        mclk      = 1'b0;
  logic        rst       = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [3:0]  pstrb     = 4'h0;
  logic [7:0]  opt_in    = 8'hFF;
  logic [3:0]  ev        = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdog_en;
  logic [17:0] wdog_to;
  logic        sup_en;
  logic        reg_en;
  logic        mon_act;
  logic        mon_rst;
  logic [12:0] rec;
  logic        stop_ent;
  logic        illegal;
  logic        intosc;
  logic        rcosc;
  logic        xtal;
  logic [1:0]  tb_sel;
  logic        baud;
  logic [1:0]  main_sel;
  logic        lock1;
  logic        lock2;
  int          n_fail    = 0;
  int          num_checks = 0;
  logic [7:0]  c1;
  logic [7:0]  c2;

  always #50 mclk = ~mclk;

  wor_option_regs wor_option_regs_i (
    .MCLK_IN(mclk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .OPTION_BYTE_IN(opt_in),
    .STOP_MODE_IN(ev[3]), .STOP_EXIT_PIN_IN(ev[2]),
    .STOP_OPCODE_IN(ev[1]), .MON_RESET_REQ_IN(ev[0]),
    .WDOG_ENABLE_OUT(wdog_en), .WDOG_TIMEOUT_OUT(wdog_to),
    .SUPPLY_MON_EN_OUT(sup_en), .REGULATOR_MON_EN_OUT(reg_en),
    .MON_ACTIVE_OUT(mon_act), .MON_RESET_OUT(mon_rst),
    .STOP_RECOVERY_OUT(rec), .STOP_ENTER_OUT(stop_ent),
    .ILLEGAL_OPCODE_OUT(illegal), .INTOSC_RUN_OUT(intosc),
    .RCOSC_RUN_OUT(rcosc), .XTAL_RUN_OUT(xtal),
    .TIMEBASE_CLK_SEL_OUT(tb_sel), .SERIAL_BAUD_BUS_OUT(baud),
    .MAIN_OSC_SEL_OUT(main_sel), .CFG_ONE_LOCKED_OUT(lock1),
    .CFG_TWO_LOCKED_OUT(lock2)
  );

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until PREADY is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      $display("MISMATCH t=%0t no ready", $time);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] r;
    logic        er;
    apb(1'b0, a, 32'h0000_0000, 4'h0, r, er);
    chk(r, {24'h00_0000, e}, "readback");
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [7:0] d,
                        input logic [3:0] s, input logic e_err);
    logic [31:0] r;
    logic        er;
    apb(1'b1, a, {24'hA5_A5A5, d}, s, r, er);
    chk({31'h0, er}, {31'h0, e_err}, "write error");
  endtask

  // ****************************************************************
  // Control outputs against settings and system events
  // ****************************************************************
  task automatic ctl_chk();
    logic st, pin, opc, req, on;
    ev <= 4'($urandom);
    @(posedge mclk);
    @(posedge mclk);
    #1;
    {st, pin, opc, req} = ev;
    on = !st || c1[6];
    chk({wdog_en, wdog_to}, {!c1[0], c1[7] ? 18'((1 << 13) - (1 << 4)) :
        18'((1 << 18) - (1 << 4))}, "watchdog");
    chk({sup_en, reg_en, mon_act, mon_rst}, {!c1[4] && on, !c1[3] && on,
        (!c1[4] || !c1[3]) && on, req && !c1[5]}, "monitor");
    chk({rec, stop_ent, illegal}, {(c1[2] && !pin) ? 13'h0020 : 13'h1000,
        opc && c1[1], opc && !c1[1]}, "stop");
    chk({intosc, rcosc, xtal}, {!(st && c2[7]), !st || c2[6],
        !st || c2[5]}, "oscillators");
    chk({tb_sel, baud, main_sel}, {c2[4:3], c2[0], opt_in[7:6]},
        "clock routing");
    // Return on an edge so the next drive starts right after it
    @(posedge mclk);
  endtask

  // ****************************************************************
  // One round: reset, refusals, the one write, ignored rewrite
  // ****************************************************************
  task automatic round(input int k);
    logic [7:0] v1, v2;
    opt_in <= {2'(k == 1 ? 0 : $urandom), 6'h3F};
    v1 = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
    v2 = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    c1 = 8'h00;
    c2 = 8'h00;
    if (opt_in[7:6] == 2'b11) v1[2] = 1'b0;
    if (!v1[6] || (v1[4] && v1[3])) v1[5] = 1'b1;
    ctl_chk();
    rd_chk(wor_pkg::CFG_ONE_ADDR, 8'h00);
    rd_chk(wor_pkg::CFG_TWO_ADDR, 8'h00);
    rd_chk(wor_pkg::OPT_ADDR, opt_in);
    // Lane 0 off must neither land nor lock
    wr_chk(wor_pkg::CFG_ONE_ADDR, ~v1, 4'hE, 1'b0);
    chk({31'h0, lock1}, 32'h0000_0000, "lock before write");
    wr_chk(12'h000, v1, 4'hF, 1'b1);
    wr_chk(wor_pkg::OPT_ADDR, 8'h00, 4'hF, 1'b1);
    rd_chk(wor_pkg::OPT_ADDR, opt_in);
    wr_chk(wor_pkg::CFG_ONE_ADDR, v1, 4'hF, 1'b0);
    wr_chk(wor_pkg::CFG_TWO_ADDR, v2, 4'hF, 1'b0);
    c1 = v1;
    c2 = v2 & wor_pkg::CFG_TWO_WMASK;
    chk({30'h0, lock1, lock2}, 32'h0000_0003, "locks");
    rd_chk(wor_pkg::CFG_ONE_ADDR, c1);
    rd_chk(wor_pkg::CFG_TWO_ADDR, c2);
    wr_chk(wor_pkg::CFG_ONE_ADDR, ~v1, 4'hF, 1'b0);
    wr_chk(wor_pkg::CFG_TWO_ADDR, ~v2, 4'hF, 1'b0);
    rd_chk(wor_pkg::CFG_ONE_ADDR, c1);
    rd_chk(wor_pkg::CFG_TWO_ADDR, c2);
    repeat (24) ctl_chk();
    $display("round %0d done, mismatches %0d", k, n_fail);
  endtask

  initial begin
    void'($urandom(32'h1da6_7a20));
    @(posedge mclk);
    for (int k = 0; k < 8; k++) begin
      round(k);
    end
    test_done();
  end
endmodule

`default_nettype wire
